//--- design/irq_ctrl_pkg.sv
package irq_ctrl_pkg;

  // bus geometry and block placement in the device map
  localparam int unsigned ADDR_W      = 24;
  localparam int unsigned DATA_W      = 16;
  localparam logic [23:0] BLOCK_BASE  = 24'h00f0e0;
  localparam logic [18:0] BLOCK_SPAN  = 19'h00000;   // upper offset bits of any hit

  // register offsets, in words from the block base
  localparam logic [7:0] OFS_PRIO0    = 8'h00;
  localparam logic [7:0] OFS_PRIO6    = 8'h06;
  localparam logic [7:0] OFS_VTB      = 8'h07;
  localparam logic [7:0] OFS_QMATCH0  = 8'h08;
  localparam logic [7:0] OFS_QLOW0    = 8'h09;
  localparam logic [7:0] OFS_QHIGH0   = 8'h0a;
  localparam logic [7:0] OFS_QMATCH1  = 8'h0b;
  localparam logic [7:0] OFS_QLOW1    = 8'h0c;
  localparam logic [7:0] OFS_QHIGH1   = 8'h0d;
  localparam logic [7:0] OFS_PEND0    = 8'h0e;
  localparam logic [7:0] OFS_PEND1    = 8'h0f;
  localparam logic [7:0] OFS_PEND2    = 8'h10;
  localparam logic [7:0] OFS_PEND3    = 8'h11;
  localparam logic [7:0] OFS_EVT_STAT = 8'h12;
  localparam logic [7:0] OFS_EVT_MASK = 8'h13;
  localparam logic [7:0] OFS_CTL      = 8'h16;

  // priority fields
  localparam int unsigned PRIO_REGS   = 7;
  localparam int unsigned FIELDS      = 56;
  localparam logic [15:0] PRIO_RESET  = 16'h0000;
  localparam logic [15:0] PRIO0_WMASK = 16'hf3ff;    // bits 11:10 reserved
  localparam logic [15:0] PRIO6_WMASK = 16'h0fff;    // bits 15:12 reserved
  localparam logic [15:0] PRIO_WMASK  = 16'hffff;
  localparam logic [1:0]  QUICK_LEVEL = 2'h2;

  // field widths of the address registers
  localparam int unsigned VTB_W       = 14;
  localparam int unsigned MATCH_W     = 6;
  localparam int unsigned QHIGH_W     = 5;
  localparam int unsigned VADDR_W     = 21;

  // sources
  localparam int unsigned SRC_COUNT   = 64;
  localparam int unsigned FIRST_SRC   = 2;

  // control and status word layout
  localparam int unsigned CTL_ACTIVE  = 15;
  localparam int unsigned CTL_LVL_LO  = 13;
  localparam int unsigned CTL_VEC_LO  = 6;
  localparam int unsigned CTL_OFF     = 5;
  localparam logic [4:0]  CTL_FIXED   = 5'h1c;       // bits 4:2 read one, 1:0 zero

  // event status bits
  localparam int unsigned EVT_W       = 3;
  localparam int unsigned EVT_WAKE    = 0;
  localparam int unsigned EVT_PRESENT = 1;
  localparam int unsigned EVT_QUICK   = 2;

  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  level;
    logic [5:0]  number;
    logic [20:0] addr;
  } core_req_t;

endpackage : irq_ctrl_pkg

//--- design/irq_arbiter_unit.sv
`timescale 1ns/1ps
// Functional notes
// [RL1] After reset the controller presents requests at once, needing no setup; the code resets every priority field to zero, so a field must be written first.
// [RL2] While in wait or stop, a pending enabled request raises the wake request.
// [RL3] Only sources enabled before low power was entered can raise the wake request.
// [RL4] Each register answers at the block base address plus its offset.
// [RL5] Seven priority words at offsets 0 to 6 hold 2-bit fields, read and written.
// [RL6] The first priority word holds seven source fields, bits 11 and 10 read zero.
// [RL7] The first priority word resets to zero, all of its sources disabled.
// [RL8] The vector table base holds bits 13 to 0, bits 15 and 14 read zero.
// [RL9] Each quick match word holds a 6-bit vector number, upper bits read zero.
// [RL10] Each quick address has a 16-bit low word and a 5-bit high word.
// [RL11] Four pending words show sources 2 to 63 in order, bit 0 of the first is one.
// [RL12] The second quick address set sits after its own match word, like the first.
// [RL13] Within one level the lowest numbered active source wins.
// [RL14] A normal vector is the table base joined with the source vector number.
// [RL15] A level 2 winner matching a quick match word takes that quick address.
// [RL16] The current level field shows 00 none, 01 level 0, 10 level 1, 11 level 2 or 3.
// [RL17] A zero priority field disables its source for arbitration and wake.
module irq_arbiter_unit
  #(parameter int unsigned SOURCES = 64)
  (input  wire logic                    clk_in,
   input  wire logic                    rst_n_in,
   input  wire irq_ctrl_pkg::bus_req_t  bus_in,
   input  wire logic [63:0]             irq_lines_in,
   input  wire logic [1:0]              core_mask_in,
   input  wire logic                    low_power_in,
   output logic [15:0]                  rdata_out,
   output irq_ctrl_pkg::core_req_t      core_out,
   output logic                         wake_out,
   output logic                         irq_out);

  import irq_ctrl_pkg::*;

  // the source layout is fixed by the register map
  if (SOURCES != SRC_COUNT) begin : bad_sources
    $error("irq_arbiter_unit serves exactly 64 sources");
  end

  logic [6:0][15:0]     prio_r;
  logic [VTB_W-1:0]     vtb_r;
  logic [MATCH_W-1:0]   qmatch_r [2];
  logic [15:0]          qlow_r   [2];
  logic [QHIGH_W-1:0]   qhigh_r  [2];
  logic                 irq_off_r;
  logic [EVT_W-1:0]     evt_stat_r;
  logic [EVT_W-1:0]     evt_mask_r;
  logic [EVT_W-1:0]     evt_stat_nxt;
  logic [15:0]          rdata_r;
  core_req_t            core_r;
  core_req_t            core_nxt;
  logic                 wake_r;
  logic                 irq_r;
  logic [63:0]          wake_en_r;
  logic                 seen_r;

  logic [23:0]          ofs_full;
  logic                 sel;
  logic [7:0]           ofs;
  logic                 wr_hit;
  logic                 rd_hit;
  logic [63:0]          enabled;
  logic [63:0]          active;
  logic [1:0]           lvl [64];
  logic [2:0]           best_code;
  logic [5:0]           win_num;
  logic                 found;
  logic                 accept;
  logic                 present;
  logic [1:0]           quick_hit;
  logic                 wake_nxt;

  // mask of writable bits for each priority word
  function automatic logic [15:0] prio_wmask(input int unsigned idx);
    if (idx == 0)
      return PRIO0_WMASK;
    else if (idx == PRIO_REGS - 1)
      return PRIO6_WMASK;
    else
      return PRIO_WMASK;
  endfunction : prio_wmask

  // encode a granted level for the current level field
  function automatic logic [1:0] level_code(input logic valid, input logic [1:0] level);
    if (!valid)
      return 2'h0;
    else if (level >= 2'h2)
      return 2'h3;
    else
      return level + 2'h1;
  endfunction : level_code

  // address decode relative to the block base
  // [RL4] base plus offset
  always_comb
  begin
    ofs_full = bus_in.addr - BLOCK_BASE;
    sel      = (ofs_full[23:5] == BLOCK_SPAN);
    ofs      = ofs_full[7:0];
    wr_hit   = bus_in.wr && sel;
    rd_hit   = bus_in.rd && sel;
  end

  // per-source enable and level from the packed priority fields
  // [RL17] zero field disables
  always_comb
  begin
    int unsigned k;
    logic [1:0]  f;
    k = 0;
    f = 2'h0;
    enabled = '0;
    for (int s = 0; s < 64; s++)
    begin
      lvl[s] = 2'h0;
      if (s >= FIRST_SRC && (s - FIRST_SRC) < FIELDS)
      begin
        k = s - FIRST_SRC;
        f = prio_r[k / 8][15 - 2 * (k % 8) -: 2];
        enabled[s] = (f != 2'h0);
        // the first word encodes levels 1 to 3, the others 0 to 2
        lvl[s] = (k < 8) ? f : f - 2'h1;
      end
    end
    active = irq_lines_in & enabled;
  end

  // pick the highest level, lowest numbered source at that level
  // [RL13] lowest number wins
  always_comb
  begin
    logic [2:0] code;
    code = 3'h0;
    best_code = 3'h0;
    win_num = 6'h00;
    for (int s = 63; s >= 0; s--)
    begin
      code = active[s] ? {1'b0, lvl[s]} + 3'h1 : 3'h0;
      if (code != 3'h0 && code >= best_code)
      begin
        best_code = code;
        win_num = 6'(s);
      end
    end
    found = (best_code != 3'h0);
  end

  // core masking, quick match and vector formation
  always_comb
  begin
    accept  = found && ((best_code[1:0] - 2'h1) >= core_mask_in);
    // [RL1] off bit clear after reset, but a source needs a nonzero priority field
    present = accept && !irq_off_r;
    for (int q = 0; q < 2; q++)
      quick_hit[q] = (best_code[1:0] - 2'h1 == QUICK_LEVEL) && (win_num == qmatch_r[q]);
    core_nxt.valid  = present;
    core_nxt.level  = present ? best_code[1:0] - 2'h1 : 2'h0;
    core_nxt.number = present ? win_num : 6'h00;
    // [RL15] quick address first
    if (!present)
      core_nxt.addr = '0;
    else if (quick_hit[0])
      core_nxt.addr = {qhigh_r[0], qlow_r[0]};
    else if (quick_hit[1])
      core_nxt.addr = {qhigh_r[1], qlow_r[1]};
    else
      // [RL14] base joined with number
      core_nxt.addr = {vtb_r, win_num, 1'b0};
  end

  // priority words, writable fields only
  // [RL5] priority read write
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      // [RL7] reset disables all
      prio_r <= {PRIO_REGS{PRIO_RESET}};
    else
      for (int i = 0; i < PRIO_REGS; i++)
        if (wr_hit && ofs == OFS_PRIO0 + 8'(i))
          // [RL6] reserved bits held zero
          prio_r[i] <= bus_in.wdata & prio_wmask(i);
  end

  // vector base and quick address sets
  // [RL12] second set after its match
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      vtb_r <= '0;
      for (int q = 0; q < 2; q++)
      begin
        qmatch_r[q] <= '0;
        qlow_r[q]   <= '0;
        qhigh_r[q]  <= '0;
      end
    end
    else if (wr_hit)
    begin
      // [RL8] base field only
      if (ofs == OFS_VTB)
        vtb_r <= bus_in.wdata[VTB_W-1:0];
      for (int q = 0; q < 2; q++)
      begin
        // [RL9] six bit match
        if (ofs == OFS_QMATCH0 + 8'(3 * q))
          qmatch_r[q] <= bus_in.wdata[MATCH_W-1:0];
        // [RL10] low and high words
        if (ofs == OFS_QLOW0 + 8'(3 * q))
          qlow_r[q] <= bus_in.wdata;
        if (ofs == OFS_QHIGH0 + 8'(3 * q))
          qhigh_r[q] <= bus_in.wdata[QHIGH_W-1:0];
      end
    end
  end

  // control word and event mask
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      irq_off_r  <= 1'b0;
      evt_mask_r <= '0;
    end
    else if (wr_hit)
    begin
      if (ofs == OFS_CTL)
        irq_off_r <= bus_in.wdata[CTL_OFF];
      if (ofs == OFS_EVT_MASK)
        evt_mask_r <= bus_in.wdata[EVT_W-1:0];
    end
  end

  // sticky events, write one to clear, a new event beats the clear
  always_comb
  begin
    logic [EVT_W-1:0] clr;
    logic [EVT_W-1:0] set;
    clr = (wr_hit && ofs == OFS_EVT_STAT) ? bus_in.wdata[EVT_W-1:0] : '0;
    set = '0;
    set[EVT_WAKE]    = wake_nxt && !wake_r;
    set[EVT_PRESENT] = present && !core_r.valid;
    set[EVT_QUICK]   = present && (quick_hit != 2'h0)
                       && (core_nxt.number != core_r.number || !core_r.valid);
    evt_stat_nxt = (evt_stat_r & ~clr) | set;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      evt_stat_r <= '0;
      irq_r      <= 1'b0;
    end
    else
    begin
      evt_stat_r <= evt_stat_nxt;
      irq_r      <= |(evt_stat_nxt & evt_mask_r);
    end
  end

  // wake sources are frozen at low power entry
  // [RL3] enabled before entry
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      wake_en_r <= '0;
    else if (!low_power_in)
      wake_en_r <= enabled;
  end

  // [RL2] wake on pending request
  assign wake_nxt = low_power_in && |(irq_lines_in & wake_en_r);

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wake_r <= 1'b0;
      core_r <= '0;
      seen_r <= 1'b0;
    end
    else
    begin
      wake_r <= wake_nxt;
      core_r <= core_nxt;
      seen_r <= 1'b1;
    end
  end

  // read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rdata_r <= '0;
    else if (!rd_hit)
      rdata_r <= '0;
    else
      case (ofs)
        8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06:
          rdata_r <= prio_r[ofs[2:0]];
        OFS_VTB:      rdata_r <= {2'h0, vtb_r};
        OFS_QMATCH0:  rdata_r <= {10'h000, qmatch_r[0]};
        OFS_QLOW0:    rdata_r <= qlow_r[0];
        OFS_QHIGH0:   rdata_r <= {11'h000, qhigh_r[0]};
        OFS_QMATCH1:  rdata_r <= {10'h000, qmatch_r[1]};
        OFS_QLOW1:    rdata_r <= qlow_r[1];
        OFS_QHIGH1:   rdata_r <= {11'h000, qhigh_r[1]};
        // [RL11] pending words in order
        OFS_PEND0:    rdata_r <= {irq_lines_in[16:2], 1'b1};
        OFS_PEND1:    rdata_r <= irq_lines_in[32:17];
        OFS_PEND2:    rdata_r <= irq_lines_in[48:33];
        OFS_PEND3:    rdata_r <= {1'b0, irq_lines_in[63:49]};
        OFS_EVT_STAT: rdata_r <= {13'h0000, evt_stat_r};
        OFS_EVT_MASK: rdata_r <= {13'h0000, evt_mask_r};
        // [RL16] current level code
        OFS_CTL:      rdata_r <= {core_r.valid, level_code(core_r.valid, core_r.level),
                                  1'b0, core_r.number, irq_off_r, CTL_FIXED};
        default:      rdata_r <= '0;
      endcase
  end

  assign rdata_out = rdata_r;
  assign core_out  = core_r;
  assign wake_out  = wake_r;
  assign irq_out   = irq_r;

  // checks

  first_state_a : assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL7]
    !seen_r |-> prio_r[0] == 16'h0000 && !irq_off_r && !core_r.valid)
    else $error("state after reset not cleared");

  ready_now_a : assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL1]
    present |=> core_out.valid && core_out.number == $past(win_num))
    else $error("request not presented in the next cycle");

  wake_raise_a : assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL2]
    low_power_in && |(irq_lines_in & wake_en_r) |=> wake_out)
    else $error("wake not raised for pending request");

  wake_cause_a : assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL3]
    wake_out |-> $past(low_power_in) && $past(|(irq_lines_in & wake_en_r)))
    else $error("wake raised without enabled source");

  base_read_a : assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL4]
    bus_in.rd && bus_in.addr == BLOCK_BASE + 24'h000007
    |=> rdata_out == {2'h0, $past(vtb_r)})
    else $error("table base not read at block base plus offset");

  prio_write_a : assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL5]
    bus_in.wr && bus_in.addr == BLOCK_BASE + 24'h000001
    |=> prio_r[1] == $past(bus_in.wdata))
    else $error("priority word not written");

  reserved_zero_a : assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL6]
    prio_r[0][11:10] == 2'h0 && prio_r[6][15:12] == 4'h0)
    else $error("reserved priority bits set");

  upper_zero_a : assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL8]
    rd_hit && ofs == OFS_VTB |=> rdata_out[15:14] == 2'h0)
    else $error("upper bits of table base not zero");

  quick_upper_a : assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL9]
    rd_hit && (ofs == OFS_QMATCH0 || ofs == OFS_QMATCH1) |=> rdata_out[15:6] == 10'h000)
    else $error("upper bits of quick match not zero");

  pend_first_a : assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL11]
    rd_hit && ofs == OFS_PEND0 |=> rdata_out == {$past(irq_lines_in[16:2]), 1'b1})
    else $error("first pending word wrong");

  normal_vec_a : assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL14]
    present && quick_hit == 2'h0
    |=> core_out.addr == {$past(vtb_r), $past(win_num), 1'b0})
    else $error("normal vector not formed from base and number");

  quick_vec_a : assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL15]
    present && quick_hit[0] |=> core_out.addr == {$past(qhigh_r[0]), $past(qlow_r[0])}
    && core_out.level == 2'h2)
    else $error("quick address not used");

  level_read_a : assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL16]
    rd_hit && ofs == OFS_CTL && core_r.valid && core_r.level == 2'h0
    |=> rdata_out[14:13] == 2'h1)
    else $error("current level code wrong");

  enabled_only_a : assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RL17]
    present |-> enabled[win_num] && irq_lines_in[win_num])
    else $error("disabled source presented");

endmodule : irq_arbiter_unit

//--- bench/irq_source_model.sv
`timescale 1ns/1ps
// peripheral request lines as the controller sees them
module irq_source_model
  (input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic [63:0] req_in,
   input  wire logic        slow_in,
   output logic [63:0]      lines_out);
  logic [63:0] stage_r;
  // slow peripherals answer a cycle later than prompt ones
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      stage_r   <= 64'h0;
      lines_out <= 64'h0;
    end
    else
    begin
      stage_r   <= req_in;
      lines_out <= slow_in ? stage_r : req_in;
    end
  end
endmodule : irq_source_model

//--- bench/prioritised_irq_controller_regs_tb_top.sv
`timescale 1ns/1ps
module prioritised_irq_controller_regs_tb_top;
  import irq_ctrl_pkg::*;
  logic        clk_in;
  logic        rst_n_in;
  bus_req_t    bus;
  logic [63:0] req;
  logic [63:0] lines;
  logic [63:0] ln;
  logic        slow;
  logic        lp;
  logic [1:0]  cmask;
  logic [15:0] rdata;
  logic [15:0] d;
  core_req_t   core;
  core_req_t   c;
  logic        wake;
  logic        irq;
  logic        off;
  int          errors;
  int          n_compared;
  int          cyc;
  logic [15:0] sh [0:13];
  // writable bits of each word at offsets 0 to 13
  localparam logic [15:0] WM [0:13] = '{16'hf3ff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
    16'hffff, 16'h0fff, 16'h3fff, 16'h003f, 16'hffff, 16'h001f, 16'h003f, 16'hffff, 16'h001f};

  irq_arbiter_unit #(.SOURCES(64)) DUT
    (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus_in(bus), .irq_lines_in(lines),
     .core_mask_in(cmask), .low_power_in(lp), .rdata_out(rdata), .core_out(core),
     .wake_out(wake), .irq_out(irq));

  irq_source_model PER
    (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req), .slow_in(slow), .lines_out(lines));

  // clock and hang guard
  initial clk_in = 1'b0;
  always #10 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk_core(input core_req_t got, input core_req_t exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %0t: core %h expected %h", $time, got, exp);
    end
  endtask : chk_core

  // one-cycle write strobe, shadow keeps the writable bits
  task automatic wr(input logic [7:0] ofs, input logic [15:0] dat);
    @(posedge clk_in);
    bus.addr  <= BLOCK_BASE + 24'(ofs);
    bus.wdata <= dat;
    bus.wr    <= 1'b1;
    @(posedge clk_in);
    bus.wr <= 1'b0;
    if (ofs < 8'h0e) sh[ofs] = dat & WM[ofs];
    if (ofs == OFS_CTL) off = dat[5];
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [23:0] a, output logic [15:0] dat);
    @(posedge clk_in);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clk_in);
    bus.rd <= 1'b0;
    #1;
    dat = rdata;
  endtask : rd

  // winner: highest level, then lowest source; quick address on level 2 match
  function automatic core_req_t exp_core(logic [63:0] l, logic [1:0] m);
    core_req_t r;
    logic [1:0] f;
    int k;
    int lv;
    int best;
    int bs;
    r = '0;
    best = -1;
    bs = 0;
    for (int s = 2; s < 58; s++)
    begin
      k = s - 2;
      f = sh[k / 8][15 - 2 * (k % 8) -: 2];
      lv = (k < 8) ? int'(f) : int'(f) - 1;
      if (f != 2'h0 && l[s] && lv > best)
      begin
        best = lv;
        bs = s;
      end
    end
    if (best >= int'(m) && !off)
    begin
      r.valid  = 1'b1;
      r.level  = 2'(best);
      r.number = 6'(bs);
      r.addr   = {sh[7][13:0], 6'(bs), 1'b0};
      if (best == 2 && 6'(bs) == sh[8][5:0])
        r.addr = {sh[10][4:0], sh[9]};
      else if (best == 2 && 6'(bs) == sh[11][5:0])
        r.addr = {sh[13][4:0], sh[12]};
    end
    return r;
  endfunction : exp_core

  function automatic logic [15:0] exp_ctl(core_req_t r);
    logic [1:0] code;
    code = !r.valid ? 2'h0 : (r.level == 2'h0 ? 2'h1 : (r.level == 2'h1 ? 2'h2 : 2'h3));
    return {r.valid, code, 1'b0, r.number, off, 5'h1c};
  endfunction : exp_ctl

  // drive lines and mask, then check what the core is offered
  task automatic arb(input logic [63:0] l, input logic [1:0] m);
    @(posedge clk_in);
    req   <= l;
    cmask <= m;
    repeat (4) @(posedge clk_in);
    #1;
    chk_core(core, exp_core(l, m));
    rd(BLOCK_BASE + 24'(OFS_CTL), d);
    chk16(d, exp_ctl(exp_core(l, m)));
  endtask : arb

  initial
  begin
    bus = '0;
    req = '0;
    slow = 1'b0;
    lp = 1'b0;
    cmask = 2'h0;
    off = 1'b0;
    rst_n_in = 1'b0;
    errors = 0;
    n_compared = 0;
    cyc = 0;
    for (int i = 0; i < 14; i++) sh[i] = 16'h0;
    void'($urandom(32'h3f2ed323));
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    #1;
    chk_core(core, '0);
    chk16({14'h0, wake, irq}, 16'h0);
    rd(BLOCK_BASE, d);
    chk16(d, 16'h0);
    wr(OFS_PRIO0, 16'h4000);
    arb(64'h4, 2'h0);
    rd(BLOCK_BASE + 24'(OFS_EVT_STAT), d);
    chk16(d, 16'h0002);
    chk16({15'h0, irq}, 16'h0);
    wr(OFS_EVT_MASK, 16'h0002);
    repeat (2) @(posedge clk_in);
    #1;
    chk16({15'h0, irq}, 16'h1);
    wr(OFS_EVT_STAT, 16'h0002);
    repeat (2) @(posedge clk_in);
    #1;
    chk16({15'h0, irq}, 16'h0);
    @(posedge clk_in);
    lp <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    chk16({15'h0, wake}, 16'h1);
    // a source enabled while asleep, and a source never enabled, stay quiet
    wr(OFS_PRIO0, 16'h5000);
    @(posedge clk_in);
    req <= 64'h8;
    repeat (4) @(posedge clk_in);
    #1;
    chk16({15'h0, wake}, 16'h0);
    @(posedge clk_in);
    req <= 64'h20;
    repeat (4) @(posedge clk_in);
    #1;
    chk16({15'h0, wake}, 16'h0);
    @(posedge clk_in);
    lp  <= 1'b0;
    req <= '0;
    wr(OFS_EVT_STAT, 16'h0007);
    wr(OFS_EVT_MASK, 16'h0000);
    for (int i = 0; i < 14; i++)
    begin
      wr(8'(i), 16'($urandom));
      rd(BLOCK_BASE + 24'(i), d);
      chk16(d, sh[i]);
    end
    wr(8'h14, 16'hffff);
    rd(BLOCK_BASE + 24'h14, d);
    chk16(d, 16'h0);
    rd(BLOCK_BASE + 24'h20, d);
    chk16(d, 16'h0);
    ln = {$urandom, $urandom};
    wr(OFS_PEND0, 16'h0);
    @(posedge clk_in);
    req <= ln;
    repeat (4) @(posedge clk_in);
    rd(BLOCK_BASE + 24'(OFS_PEND0), d);
    chk16(d, {ln[16:2], 1'b1});
    rd(BLOCK_BASE + 24'(OFS_PEND1), d);
    chk16(d, ln[32:17]);
    rd(BLOCK_BASE + 24'(OFS_PEND2), d);
    chk16(d, ln[48:33]);
    rd(BLOCK_BASE + 24'(OFS_PEND3), d);
    chk16(d, {1'b0, ln[63:49]});
    // random arbitration with quick matches steered
    for (int i = 0; i < 40; i++)
    begin
      for (int w = 0; w < 10; w++) wr(8'(w), 16'($urandom));
      ln = {$urandom & $urandom, $urandom & $urandom};
      c = exp_core(ln, 2'h0);
      wr(OFS_QMATCH0, (i % 3 == 0) ? {10'h0, c.number} : 16'($urandom));
      wr(OFS_QMATCH1, (i % 3 == 1) ? {10'h0, c.number} : 16'($urandom));
      wr(OFS_QLOW1, 16'($urandom));
      wr(OFS_QHIGH1, 16'($urandom));
      wr(OFS_CTL, (i % 8 == 7) ? 16'h0020 : 16'h0000);
      @(posedge clk_in);
      slow <= i[0];
      arb(ln, 2'($urandom));
    end
    test_done();
  end
endmodule : prioritised_irq_controller_regs_tb_top
